/* File: core/cst_regs.svh */
`ifndef CST_REGS_SVH
`define CST_REGS_SVH

// device clock rate, in Hz and in MHz
`define CST_CLK_HZ          20000000
`define CST_CLK_MHZ         20

// deglitch of the input limit loops and of the thermal loop, in microseconds
`define CST_INLOOP_DGL_US   1000
`define CST_THERM_DGL_US    10000
`define CST_INLOOP_DGL_CYC  (`CST_INLOOP_DGL_US * `CST_CLK_MHZ)
`define CST_THERM_DGL_CYC   (`CST_THERM_DGL_US * `CST_CLK_MHZ)

// least low time of the status pin notification, in microseconds
`define CST_PULSE_US        256
`define CST_PULSE_CYC       (`CST_PULSE_US * `CST_CLK_MHZ)

// base tick of the hour-scale timers, in seconds
`define CST_TICK_S          1
`define CST_TICK_CYC        (`CST_TICK_S * `CST_CLK_HZ)

// timer lengths, in hours, and seconds per hour
`define CST_HOUR_S          3600
`define CST_PRE_HOURS       2
`define CST_DUR0_HOURS      5
`define CST_DUR1_HOURS      8
`define CST_DUR2_HOURS      12
`define CST_DUR3_HOURS      20

// widths and reset values
`define CST_SEC_W           18
`define CST_CUR_W           11
`define CST_CUR_RST         11'h000
`define CST_DUR_SEL_RST     2'h2
`define CST_SEL_W           2

`endif

/* File: core/cst_pkg.sv */
package cst_pkg;
    // charge phase codes as reported in the status field
    typedef enum logic [2:0] {
        CST_PH_NONE  = 3'b000,
        CST_PH_TRKL  = 3'b001,
        CST_PH_PRE   = 3'b010,
        CST_PH_CC    = 3'b011,
        CST_PH_CV    = 3'b100,
        CST_PH_RSV5  = 3'b101,
        CST_PH_RSV6  = 3'b110,
        CST_PH_DONE  = 3'b111
    } cst_phase_t;
    // fast charge duration selector
    typedef logic [1:0] cst_dur_sel_t;
endpackage

/* File: core/cst_dgl_if.sv */
`timescale 1ns/1ps
// raw loop indicator in, deglitched level out
interface cst_dgl_if;
    logic raw;      // unsynchronised loop indicator
    logic active;   // deglitched loop active level
    modport filt (input raw, output active);
    modport user (output raw, input active);
endinterface // cst_dgl_if

/* File: core/cst_deglitch.sv */
`timescale 1ns/1ps
module cst_deglitch #(
    parameter int CYC = 20000   // cycles the level must hold before it counts
) (
    input  wire logic clk,      // device clock
    input  wire logic rst,      // async reset, active high
    cst_dgl_if.filt   dg        // raw in, filtered out
);
    import cst_pkg::*;
    localparam int CW = $clog2(CYC + 1);

    logic          sync1_q;     // first sync stage, read only by the second
    logic          sync2_q;     // second sync stage
    logic [CW-1:0] cnt_q;       // cycles the synced level has been high
    logic          active_q;    // filtered level

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser, the loop flags come from analog comparators
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= dg.raw;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rise deglitch only
    // a release drops at once; keeping half rate on a glitch low is worse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else if (!sync2_q) begin
            cnt_q    <= '0;
            active_q <= 1'b0;
        end else if (cnt_q != CW'(CYC)) begin
            cnt_q    <= cnt_q + CW'(1);
            active_q <= (cnt_q == CW'(CYC - 1));
        end
    end

    assign dg.active = active_q;

    ////////////////////////////////////////////////////////////////////////
    property p_dgl_rise;
        @(posedge clk) disable iff (rst)
        $rose(active_q) |-> $past(cnt_q) == CW'(CYC - 1) && $past(sync2_q);
    endproperty
    a_dgl_rise: assert property (p_dgl_rise) else $error("loop active too early");

    property p_dgl_fall;
        @(posedge clk) disable iff (rst)
        !sync2_q |=> !active_q;
    endproperty
    a_dgl_fall: assert property (p_dgl_fall) else $error("loop active after release");
endmodule // cst_deglitch

/* File: core/cst_safety_timer.sv */
`timescale 1ns/1ps
`include "cst_regs.svh"
module cst_safety_timer #(
    parameter int INLOOP_DGL_CYC = `CST_INLOOP_DGL_CYC, // 1 ms deglitch in cycles
    parameter int THERM_DGL_CYC  = `CST_THERM_DGL_CYC,  // 10 ms deglitch in cycles
    parameter int PULSE_CYC      = `CST_PULSE_CYC,      // status pin low time in cycles
    parameter int TICK_CYC       = `CST_TICK_CYC        // cycles per one second tick
) (
    input  wire logic                 CLK,                      // 20 MHz device clock
    input  wire logic                 RST,                      // async reset, high
    input  wire cst_pkg::cst_dur_sel_t TIMER_DURATION_SEL,      // fast timer length
    input  wire logic                 SAFETY_TIMER_EN,          // timer feature on
    input  wire logic                 HALF_RATE_EN,             // half rate allowed
    input  wire logic                 STATUS_PIN_EVENT_EN,      // pulse pin on expiry
    input  wire logic                 CHARGE_HOLD_OFF,          // charge inhibited
    input  wire logic                 CHARGE_CURRENT_WR,        // current setting write
    input  wire logic [`CST_CUR_W-1:0] CHARGE_CURRENT_WDATA,    // value written
    input  wire cst_pkg::cst_phase_t  CORE_PHASE,               // phase from charger core
    input  wire logic                 CHARGE_FAULT,             // fault disables charge
    input  wire logic                 RECHARGE_START,           // recharge after done
    input  wire logic                 INPUT_CURRENT_LIMIT_LOOP, // raw loop flag
    input  wire logic                 INPUT_VOLTAGE_LIMIT_LOOP, // raw loop flag
    input  wire logic                 THERMAL_LIMIT_LOOP,       // raw loop flag
    output logic [`CST_CUR_W-1:0]     CHARGE_CURRENT,           // stored current setting
    output logic                      TIMER_EXPIRED_FLAG,       // sticky expiry flag
    output cst_pkg::cst_phase_t       CHARGE_PHASE_STATUS,      // reported phase
    output logic                      CHARGER_STATUS_PIN_OUT,   // pin level when driven
    output logic                      CHARGER_STATUS_PIN_OE_N   // low while pulling down
);
    import cst_pkg::*;

    localparam int              PW      = $clog2(TICK_CYC);
    localparam int              QW      = $clog2(PULSE_CYC + 1);
    localparam logic [`CST_SEC_W-1:0] PRE_LIM =
        `CST_SEC_W'(`CST_PRE_HOURS * `CST_HOUR_S);

    ////////////////////////////////////////////////////////////////////////
    // helpers
    // fast timer length in seconds for a duration code
    function automatic logic [`CST_SEC_W-1:0] dur_limit(input cst_dur_sel_t sel);
        case (sel)
            2'h0:    dur_limit = `CST_SEC_W'(`CST_DUR0_HOURS * `CST_HOUR_S);
            2'h1:    dur_limit = `CST_SEC_W'(`CST_DUR1_HOURS * `CST_HOUR_S);
            2'h2:    dur_limit = `CST_SEC_W'(`CST_DUR2_HOURS * `CST_HOUR_S);
            default: dur_limit = `CST_SEC_W'(`CST_DUR3_HOURS * `CST_HOUR_S);
        endcase
    endfunction

    // true for the low battery phases that the pre timer covers
    function automatic logic is_pre(input cst_phase_t ph);
        is_pre = (ph == CST_PH_TRKL) || (ph == CST_PH_PRE);
    endfunction

    // true for the constant current and constant voltage phases that the fast timer covers
    function automatic logic is_fast(input cst_phase_t ph);
        is_fast = (ph == CST_PH_CC) || (ph == CST_PH_CV);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations
    cst_dgl_if iin_dg ();                 // input current loop filter
    cst_dgl_if vin_dg ();                 // input voltage loop filter
    cst_dgl_if thm_dg ();                 // thermal loop filter

    logic [`CST_CUR_W-1:0] cur_q;         // stored charge current
    logic [`CST_CUR_W-1:0] cur_d;         // its next value
    cst_dur_sel_t          sel_q;         // last seen duration code
    logic                  hold_q;        // last seen hold-off bit
    logic                  pre_q;         // last phase was a pre timer phase
    logic [PW-1:0]         presc_q;       // prescaler toward one tick
    logic                  odd_q;         // alternate tick marker for half rate
    logic [`CST_SEC_W-1:0] secs_q;        // accumulated seconds
    logic                  expired_q;     // sticky expiry
    cst_phase_t            status_q;      // reported phase
    logic [QW-1:0]         pulse_q;       // pin low cycles left
    logic [QW-1:0]         pulse_d;       // its next value
    logic                  oe_n_q;        // pin enable, low pulls down
    logic                  pin_out_q;     // driven level, always low
    logic                  in_pre;        // core in trickle or pre-charge
    logic                  charging;      // a charge cycle is in progress
    logic                  cur_restart;   // zero to nonzero current write
    logic                  reset_evt;     // any timer reset cause
    logic                  counting;      // timer may advance
    logic                  tick;          // one second elapsed
    logic                  half_cond;     // a loop asks for half rate
    logic                  accept;        // tick counts toward expiry
    logic [`CST_SEC_W-1:0] limit;         // active timer length
    logic                  expire_evt;    // timer reaches its length

    ////////////////////////////////////////////////////////////////////////
    // loop deglitch filters
    assign iin_dg.raw = INPUT_CURRENT_LIMIT_LOOP;
    assign vin_dg.raw = INPUT_VOLTAGE_LIMIT_LOOP;
    assign thm_dg.raw = THERMAL_LIMIT_LOOP;

    cst_deglitch #(.CYC(INLOOP_DGL_CYC)) u_iin_dgl (
        .clk (CLK),
        .rst (RST),
        .dg  (iin_dg)
    );
    cst_deglitch #(.CYC(INLOOP_DGL_CYC)) u_vin_dgl (
        .clk (CLK),
        .rst (RST),
        .dg  (vin_dg)
    );
    cst_deglitch #(.CYC(THERM_DGL_CYC)) u_thm_dgl (
        .clk (CLK),
        .rst (RST),
        .dg  (thm_dg)
    );

    ////////////////////////////////////////////////////////////////////////
    // phase and reset decode
    assign in_pre      = is_pre(CORE_PHASE);
    // charge runs only with current set, no hold-off and a charging phase
    assign charging    = (cur_q != '0) && !CHARGE_HOLD_OFF &&
                         (in_pre || is_fast(CORE_PHASE));
    assign cur_restart = CHARGE_CURRENT_WR && (CHARGE_CURRENT_WDATA != '0) &&
                         (cur_q == '0);

    assign reset_evt = (CHARGE_HOLD_OFF != hold_q) || RECHARGE_START || cur_restart ||
                       (in_pre != pre_q) || (TIMER_DURATION_SEL != sel_q) ||
                       !SAFETY_TIMER_EN;

    assign counting  = SAFETY_TIMER_EN && charging && !CHARGE_FAULT && !expired_q &&
                       !reset_evt;

    assign half_cond = HALF_RATE_EN && (iin_dg.active || vin_dg.active || thm_dg.active);

    // prescaled tick, alternate ticks under half rate
    assign tick      = counting && (presc_q == PW'(TICK_CYC - 1));
    assign accept    = tick && (!half_cond || odd_q);

    assign limit      = in_pre ? PRE_LIM : dur_limit(TIMER_DURATION_SEL);
    assign expire_evt = accept && (secs_q == limit - `CST_SEC_W'(1));

    ////////////////////////////////////////////////////////////////////////
    // history of the bits whose changes reset the timer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sel_q  <= `CST_DUR_SEL_RST;
            hold_q <= 1'b0;
            pre_q  <= 1'b0;
        end else begin
            sel_q  <= TIMER_DURATION_SEL;
            hold_q <= CHARGE_HOLD_OFF;
            pre_q  <= in_pre;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and half rate marker
    // the prescaler holds through a fault so a suspended second is not lost
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            presc_q <= '0;
            odd_q   <= 1'b0;
        end else if (reset_evt) begin
            presc_q <= '0;
            odd_q   <= 1'b0;
        end else if (tick) begin
            presc_q <= '0;
            odd_q   <= half_cond ? !odd_q : odd_q;
        end else if (counting) begin
            presc_q <= presc_q + PW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // accumulated seconds
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            secs_q <= '0;
        end else if (reset_evt) begin
            secs_q <= '0;
        end else if (accept) begin
            secs_q <= secs_q + `CST_SEC_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky expiry flag, the set wins over a clear in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            expired_q <= 1'b0;
        end else if (expire_evt) begin
            expired_q <= 1'b1;
        end else if (reset_evt) begin
            expired_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stored charge current, expiry overrides a write in the same cycle
    always_comb begin
        cur_d = cur_q;
        if (expire_evt) begin
            cur_d = '0;
        end else if (CHARGE_CURRENT_WR) begin
            cur_d = CHARGE_CURRENT_WDATA;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cur_q <= `CST_CUR_RST;
        end else begin
            cur_q <= cur_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reported phase
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            status_q <= CST_PH_NONE;
        end else if (expire_evt || (expired_q && !reset_evt)) begin
            status_q <= CST_PH_NONE;
        end else begin
            status_q <= CORE_PHASE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status pin notification, a new expiry restarts the full low time
    always_comb begin
        pulse_d = pulse_q;
        if (expire_evt && STATUS_PIN_EVENT_EN) begin
            pulse_d = QW'(PULSE_CYC);
        end else if (pulse_q != '0) begin
            pulse_d = pulse_q - QW'(1);
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pulse_q   <= '0;
            oe_n_q    <= 1'b1;
            pin_out_q <= 1'b0;
        end else begin
            pulse_q   <= pulse_d;
            oe_n_q    <= (pulse_d == '0);
            pin_out_q <= 1'b0;
        end
    end

    assign CHARGE_CURRENT          = cur_q;
    assign TIMER_EXPIRED_FLAG      = expired_q;
    assign CHARGE_PHASE_STATUS     = status_q;
    assign CHARGER_STATUS_PIN_OUT  = pin_out_q;
    assign CHARGER_STATUS_PIN_OE_N = oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_zero_cur;
        @(posedge CLK) disable iff (RST)
        expire_evt |=> CHARGE_CURRENT == '0;
    endproperty
    a_zero_cur: assert property (p_zero_cur) else $error("current not zeroed");

    property p_flag_stat;
        @(posedge CLK) disable iff (RST)
        expire_evt |=> TIMER_EXPIRED_FLAG && CHARGE_PHASE_STATUS == CST_PH_NONE;
    endproperty
    a_flag_stat: assert property (p_flag_stat) else $error("expiry status wrong");

    property p_pin_pulse;
        @(posedge CLK) disable iff (RST)
        expire_evt && STATUS_PIN_EVENT_EN |=> !CHARGER_STATUS_PIN_OE_N [*8];
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("status pulse short");

    property p_flag_hold;
        @(posedge CLK) disable iff (RST)
        TIMER_EXPIRED_FLAG && !reset_evt |=> TIMER_EXPIRED_FLAG;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_dis_none;
        @(posedge CLK) disable iff (RST)
        !SAFETY_TIMER_EN |=> !TIMER_EXPIRED_FLAG && secs_q == '0;
    endproperty
    a_dis_none: assert property (p_dis_none) else $error("disabled timer ran");

    property p_half_skip;
        @(posedge CLK) disable iff (RST)
        tick && half_cond && !odd_q |=> $stable(secs_q);
    endproperty
    a_half_skip: assert property (p_half_skip) else $error("half rate tick counted");

    property p_full_rate;
        @(posedge CLK) disable iff (RST)
        tick && !HALF_RATE_EN |=> secs_q == $past(secs_q) + `CST_SEC_W'(1);
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("full rate tick lost");

    property p_fault_hold;
        @(posedge CLK) disable iff (RST)
        CHARGE_FAULT && !reset_evt |=> $stable(secs_q) && $stable(presc_q);
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("count moved in fault");

    property p_hold_tgl;
        @(posedge CLK) disable iff (RST)
        $changed(CHARGE_HOLD_OFF) |=> secs_q == '0 && !TIMER_EXPIRED_FLAG;
    endproperty
    a_hold_tgl: assert property (p_hold_tgl) else $error("hold-off toggle no reset");

    property p_phase_rst;
        @(posedge CLK) disable iff (RST)
        in_pre != pre_q |=> secs_q == '0;
    endproperty
    a_phase_rst: assert property (p_phase_rst) else $error("phase change no reset");

    property p_sel_rst;
        @(posedge CLK) disable iff (RST)
        $changed(TIMER_DURATION_SEL) |=> secs_q == '0;
    endproperty
    a_sel_rst: assert property (p_sel_rst) else $error("duration change no reset");

    property p_pre_len;
        @(posedge CLK) disable iff (RST)
        expire_evt && in_pre |-> secs_q == PRE_LIM - `CST_SEC_W'(1);
    endproperty
    a_pre_len: assert property (p_pre_len) else $error("pre timer length wrong");
endmodule // cst_safety_timer

/* File: dv/cst_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host controller watching the open-drain status pin
module cst_host_model (
    input  wire logic clk,      // device clock
    input  wire logic pin_out,  // level driven while enabled
    input  wire logic pin_oe_n, // low while the device pulls down
    output int        low_len   // length of the last low pulse, cycles
);
    logic pin;       // wire level; the board pull-up wins when released
    int   run = 0;   // cycles low so far
    int   last = 0;  // length of the last finished low pulse
    assign pin = pin_oe_n ? 1'b1 : pin_out;
    assign low_len = last;
    // measure each low pulse; only a finished pulse is reported
    always @(posedge clk) begin
        if (pin === 1'b0) begin
            run <= run + 1;
        end else begin
            if (run != 0) last <= run;
            run <= 0;
        end
    end
endmodule // cst_host_model

/* File: dv/cst_safety_timer_bench.sv */
`timescale 1ns/1ps
module cst_safety_timer_bench;
    import cst_pkg::*;
    localparam int TK    = 2;         // short tick keeps the run small
    localparam int PULSE = 10;        // status pin low time
    localparam int PRE_L = 7200 * TK; // cycles to pre-charge expiry
    logic         clk = 0, rst = 1;   // clock and reset
    cst_dur_sel_t sel = 2'h2;         // duration code
    logic         en = 1, half = 0, evt = 1, hold = 0, wr = 0, fault = 0;
    logic         rech = 0, icl = 0, ivl = 0, thl = 0; // recharge start and loop flags
    logic [10:0]  wdata = 11'h000;    // current write data
    cst_phase_t   ph = CST_PH_NONE;   // core phase
    logic [10:0]  cur;                // stored current
    logic         flag, pout, poe_n;  // expiry flag, pin drive
    cst_phase_t   stat;               // reported phase
    int           low_len, fails = 0, n_tests = 0;
    always #25 clk = ~clk;
    cst_safety_timer #(.INLOOP_DGL_CYC(4), .THERM_DGL_CYC(8), .PULSE_CYC(PULSE),
        .TICK_CYC(TK)) i_cst_safety_timer (.CLK(clk), .RST(rst),
        .TIMER_DURATION_SEL(sel), .SAFETY_TIMER_EN(en), .HALF_RATE_EN(half),
        .STATUS_PIN_EVENT_EN(evt), .CHARGE_HOLD_OFF(hold), .CHARGE_CURRENT_WR(wr),
        .CHARGE_CURRENT_WDATA(wdata), .CORE_PHASE(ph), .CHARGE_FAULT(fault),
        .RECHARGE_START(rech), .INPUT_CURRENT_LIMIT_LOOP(icl),
        .INPUT_VOLTAGE_LIMIT_LOOP(ivl), .THERMAL_LIMIT_LOOP(thl), .CHARGE_CURRENT(cur),
        .TIMER_EXPIRED_FLAG(flag), .CHARGE_PHASE_STATUS(stat),
        .CHARGER_STATUS_PIN_OUT(pout), .CHARGER_STATUS_PIN_OE_N(poe_n));
    cst_host_model i_cst_host_model (.clk(clk), .pin_out(pout), .pin_oe_n(poe_n),
        .low_len(low_len));
    ////////////////////////////////////////////////////////////////////////////
    // compare and count; four-state compare so unknowns never match
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // a nonzero write onto a zero setting restarts the charge cycle
    task automatic start(input cst_phase_t p);
        @(posedge clk);
        ph <= p;
        wr <= 1'b1;
        wdata <= 11'h100;
        @(posedge clk);
        wr <= 1'b0;
        idle(2);
    endtask
    // bounded wait for expiry; tick phase makes the moment a few cycles loose
    task automatic wait_exp(input int lo, input int hi);
        int n;
        n = 0;
        while (flag !== 1'b1 && n <= hi) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= lo && n <= hi, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_pre;
        start(CST_PH_PRE);
        check(flag, 1'b0);                       // cleared by restart
        // a voltage loop with half rate off must not slow the timer
        @(posedge clk);
        ivl <= 1'b1;
        wait_exp(PRE_L - 6, PRE_L + 6);          // two hour limit
        check(cur, 11'h000);                     // current zeroed
        check(stat, CST_PH_NONE);                // not charging code
        check(poe_n, 1'b0);                      // pin pulled low
        idle(20);
        check(low_len, PULSE);                   // pulse length
        check(flag, 1'b1);                       // flag sticks
        @(posedge clk);
        ivl <= 1'b0;
        $display("done t_pre");
    endtask
    task automatic t_phase;
        start(CST_PH_PRE);
        check(flag, 1'b0);                       // write restart
        idle(2000);
        @(posedge clk);
        ph <= CST_PH_CC;
        idle(7000);
        check(flag, 1'b0);                       // reset on phase change
        check(stat, CST_PH_CC);                  // status passes phase
        @(posedge clk);
        ph <= CST_PH_TRKL;
        wait_exp(PRE_L - 6, PRE_L + 6);          // trickle uses pre timer
        // a hold-off toggle must clear the expired flag
        @(posedge clk);
        hold <= 1'b1;
        idle(2);
        check(flag, 1'b0);                       // hold-off toggle resets
        @(posedge clk);
        hold <= 1'b0;
        $display("done t_phase");
    endtask
    task automatic t_half_fault;
        start(CST_PH_PRE);
        @(posedge clk);
        half <= 1'b1;
        thl <= 1'b1;
        idle(4000);
        @(posedge clk);
        thl <= 1'b0;
        fault <= 1'b1;
        idle(3000);
        @(posedge clk);
        fault <= 1'b0;
        half <= 1'b0;
        icl <= 1'b1;
        idle(2000);
        @(posedge clk);
        icl <= 1'b0;
        wait_exp(PRE_L - 4000 - 12, PRE_L - 4000 + 12);
        @(posedge clk);
        sel <= 2'h0;
        idle(2);
        check(flag, 1'b0);                       // duration change resets
        check(cur, 11'h000);                     // setting stays zero
        $display("done t_half_fault");
    endtask
    task automatic t_disable;
        start(CST_PH_PRE);
        idle(4000);
        @(posedge clk);
        en <= 1'b0;
        idle(11000);
        check(flag, 1'b0);                       // no expiry when disabled
        // expiry with the pin event off must leave the pin released
        @(posedge clk);
        en <= 1'b1;
        evt <= 1'b0;
        wait_exp(PRE_L - 6, PRE_L + 6);          // counts from zero again
        check(poe_n, 1'b1);                      // no pulse when disabled
        @(posedge clk);
        rech <= 1'b1;
        @(posedge clk);
        rech <= 1'b0;
        idle(2);
        check(flag, 1'b0);                       // recharge resets
        $display("done t_disable");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // hang guard, a little beyond the planned run length
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        summarize;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_pre;
        t_phase;
        t_half_fault;
        t_disable;
        summarize;
    end
endmodule // cst_safety_timer_bench
